// *** design/waveform_trigger_detector.sv ***
// How it works
// - Edge trigger fires when the source crosses level in chosen direction.
// - Slope picks rising, falling or both crossings.
// - Either slope fires on the first qualifying edge after arming.
// - Find level loads level with half of max peak minus min peak.
// - Find level refused for external and line sources.
// - Polarity sets which crossing starts and ends a measured pulse.
// - Glitch fires on pulses shorter or longer than glitch length.
// - Width measured between successive level crossings, compared with limits.
// - Width supports exact, shorter, longer, within and outside matching.
// - External source allows only the edge type.
// - Digital sources allow edge, width and timeout types only.
// - Line source uses mains input and edge type only.
// - Only single-event mode; sequence requests are refused.
// - External source never used inside a sequence.
// - Timeout uses the single level as high/low threshold.
// - Runt, window and slew use separate upper and lower thresholds.
// - Sources: analog channels, external, line, D0 to D15, serial bus.
// - Source evaluated whether or not it is displayed.
// - Noise reject on external edge adds hysteresis around level.
// - One-touch level sets level to half the peak-to-peak amplitude, not offset by the minimum.
// - After a trigger, run post-trigger and holdoff, then idle; ignore triggers until the next arm command.
// - Within/outside use width as centre, delta each side; zero is exact.
`default_nettype none
module waveform_trigger_detector #(
   parameter int NCH   = 4,
   parameter int SW    = 16,
   parameter int CW    = 32
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   // Sample sources
   input  wire logic [NCH*SW-1:0]     analog_in,
   input  wire logic [SW-1:0]         ext_in,
   input  wire logic [SW-1:0]         line_in,
   input  wire logic [15:0]           digital_in,
   input  wire logic                  bus_event,
   // Avalon-MM slave
   input  wire logic [7:0]            address,
   input  wire logic                  read,
   input  wire logic                  write,
   input  wire logic [31:0]           writedata,
   output logic [31:0]                readdata,
   output logic                       waitrequest,
   // Trigger output
   output logic                       trig_pulse,
   output logic                       armed
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [31:0]             ctrl;
      logic [SW-1:0]           level;
      logic [SW-1:0]           upper;
      logic [SW-1:0]           lower;
      logic [CW-1:0]           width;
      logic [CW-1:0]           delta;
      logic [CW-1:0]           hold;
      logic [SW-1:0]           hyst;
      logic [SW-1:0]           pk_max;
      logic [SW-1:0]           pk_min;
      logic                    above;
      logic                    prime;
      logic                    in_pulse;
      logic                    pulse_pos;
      logic [CW-1:0]           pcount;
      logic [CW-1:0]           tcount;
      trig_pkg::acq_state_t    st;
      logic                    trig;
      logic                    refused;
      logic                    ack;
      logic [31:0]             rdata;
   } state_t;

   state_t s_reg, s_next;

   logic [4:0]   src;
   logic [2:0]   typ;
   logic [1:0]   slope;
   logic [1:0]   rng;
   logic [SW-1:0] sample;
   logic          is_dig;
   logic          above_now;
   logic          rise;
   logic          fall;
   logic          type_ok;
   logic          fire;
   logic [CW-1:0] plen;

   // Width comparison for glitch and width detectors
   function automatic logic width_match(input logic [1:0] r,
                                        input logic [CW-1:0] len,
                                        input logic [CW-1:0] w,
                                        input logic [CW-1:0] d);
      logic in_win;
      in_win = (len + d >= w) && (len <= w + d);
      case (r)
         trig_pkg::RNG_SHORTER: width_match = len < w;
         trig_pkg::RNG_LONGER:  width_match = len > w;
         trig_pkg::RNG_WITHIN:  width_match = in_win;
         trig_pkg::RNG_OUTSIDE: width_match = !in_win;
         default:               width_match = 1'b0;
      endcase
   endfunction

   // ----------------------------------------
   // Source selection and crossing
   // ----------------------------------------
   // Runs whether or not the source is displayed
   always_comb begin
      src    = s_reg.ctrl[trig_pkg::CTRL_SRC_LSB +: 5];
      typ    = s_reg.ctrl[trig_pkg::CTRL_TYPE_LSB +: 3];
      slope  = s_reg.ctrl[trig_pkg::CTRL_SLOPE_LSB +: 2];
      rng    = s_reg.ctrl[trig_pkg::CTRL_RANGE_LSB +: 2];
      is_dig = src[4];
      sample = '0;
      if (is_dig) begin
         sample = digital_in[src[3:0]] ? {SW{1'b1}} : '0;
      end else if (src == trig_pkg::SRC_EXT) begin
         sample = ext_in;
      end else if (src == trig_pkg::SRC_LINE) begin
         sample = line_in;
      end else if (src < trig_pkg::SRC_EXT && 32'(src) < NCH) begin
         sample = analog_in[src[1:0]*SW +: SW];
      end
   end

   // Threshold with optional hysteresis; digital uses midscale
   always_comb begin
      above_now = s_reg.above;
      if (is_dig) begin
         above_now = sample[SW-1];
      end else if (typ == trig_pkg::TYP_RUNT ||
                   typ == trig_pkg::TYP_WINDOW ||
                   typ == trig_pkg::TYP_SLEW) begin
         // Two thresholds give natural hysteresis
         if (sample > s_reg.upper) above_now = 1'b1;
         else if (sample < s_reg.lower) above_now = 1'b0;
      end else if (src == trig_pkg::SRC_EXT &&
                   s_reg.ctrl[trig_pkg::CTRL_NREJ_BIT]) begin
         // Level plus band must stay below full scale, the sum wraps
         if (sample > s_reg.level + s_reg.hyst) above_now = 1'b1;
         else if (sample + s_reg.hyst < s_reg.level)
            above_now = 1'b0;
      end else begin
         above_now = sample >= s_reg.level;
      end
      rise = s_reg.prime && above_now && !s_reg.above;
      fall = s_reg.prime && !above_now && s_reg.above;
   end

   // Which types each source may use
   always_comb begin
      type_ok = 1'b1;
      if (src == trig_pkg::SRC_EXT)
         type_ok = typ == trig_pkg::TYP_EDGE;
      else if (src == trig_pkg::SRC_LINE)
         type_ok = typ == trig_pkg::TYP_EDGE;
      else if (is_dig)
         type_ok = typ == trig_pkg::TYP_EDGE ||
                   typ == trig_pkg::TYP_WIDTH ||
                   typ == trig_pkg::TYP_TIMEOUT;
      // Sequences do not exist here, so asking for one blocks all firing
      if (s_reg.ctrl[trig_pkg::CTRL_SEQ_BIT])
         type_ok = 1'b0;
   end

   // ----------------------------------------
   // Event qualification
   // ----------------------------------------
   always_comb begin
      plen = s_reg.pcount + 1'b1;
      fire = 1'b0;
      case (trig_pkg::trig_type_t'(typ))
         trig_pkg::TYP_EDGE: begin
            case (slope)
               trig_pkg::SLP_POS:    fire = rise;
               trig_pkg::SLP_NEG:    fire = fall;
               trig_pkg::SLP_EITHER: fire = rise || fall;
               default:              fire = 1'b0;
            endcase
         end
         trig_pkg::TYP_GLITCH, trig_pkg::TYP_WIDTH: begin
            // Pulse ends on the opposite crossing to its start
            if (s_reg.in_pulse &&
                ((s_reg.pulse_pos && fall) || (!s_reg.pulse_pos && rise)))
               fire = typ == trig_pkg::TYP_GLITCH ?
                  width_match({1'b0, rng[0]}, plen, s_reg.width, '0) :
                  width_match(rng, plen, s_reg.width, s_reg.delta);
         end
         trig_pkg::TYP_TIMEOUT:
            // Count restarts at each crossing, so a quiet source fires
            // once when it meets the limit and not again until it crosses
            fire = !rise && !fall && plen == s_reg.width;
         default: fire = 1'b0;
      endcase
      // Decoded bus events bypass the crossing logic entirely
      if (src == trig_pkg::SRC_BUS) fire = bus_event;
      fire = fire && type_ok;
   end

   // ----------------------------------------
   // Next state, including bus
   // ----------------------------------------
   always_comb begin
      s_next         = s_reg;
      s_next.trig    = 1'b0;
      s_next.ack     = 1'b0;
      s_next.prime   = 1'b1;
      s_next.above   = above_now;
      s_next.pcount  = plen;
      // Crossings need one primed sample, so a reset never looks like
      // an edge on a source that idles high
      // Pulse tracking per polarity
      if (rise || fall) begin
         s_next.pcount = '0;
         if (slope == trig_pkg::SLP_EITHER)
            s_next.in_pulse = 1'b1;
         else
            s_next.in_pulse = (slope == trig_pkg::SLP_POS) ? rise : fall;
         s_next.pulse_pos = rise;
      end
      if (!s_reg.prime) s_next.pcount = '0;
      // Peaks follow the selected source; clear them before a find so
      // extremes of an earlier source do not skew the level
      // Peak tracking for level finder
      if (sample > s_reg.pk_max) s_next.pk_max = sample;
      if (sample < s_reg.pk_min) s_next.pk_min = sample;
      // Acquisition sequencing
      case (s_reg.st)
         trig_pkg::ST_IDLE: ;
         trig_pkg::ST_ARMED:
            if (fire) begin
               s_next.trig   = 1'b1;
               s_next.st     = trig_pkg::ST_POST;
               s_next.tcount = '0;
            end
         // Delta doubles as the post-trigger count; holdoff follows it
         trig_pkg::ST_POST: begin
            s_next.tcount = s_reg.tcount + 1'b1;
            if (s_reg.tcount >= s_reg.delta) begin
               s_next.st     = trig_pkg::ST_HOLD;
               s_next.tcount = '0;
            end
         end
         trig_pkg::ST_HOLD: begin
            s_next.tcount = s_reg.tcount + 1'b1;
            if (s_reg.tcount >= s_reg.hold) s_next.st = trig_pkg::ST_IDLE;
         end
         default: s_next.st = trig_pkg::ST_IDLE;
      endcase
      // Register access: every request stalls for exactly one cycle
      if ((read || write) && !s_reg.ack) begin
         s_next.ack = 1'b1;
      end
      // A write lands only on the edge after its stall ends, so a
      // request abandoned while stalled never touches a register
      if (read || write) begin
         if (write && s_reg.ack) begin
            case (address)
               trig_pkg::OFS_CTRL:  s_next.ctrl  = writedata;
               trig_pkg::OFS_LEVEL: s_next.level = writedata[SW-1:0];
               trig_pkg::OFS_UPPER: s_next.upper = writedata[SW-1:0];
               trig_pkg::OFS_LOWER: s_next.lower = writedata[SW-1:0];
               trig_pkg::OFS_WIDTH: s_next.width = writedata[CW-1:0];
               trig_pkg::OFS_DELTA: s_next.delta = writedata[CW-1:0];
               trig_pkg::OFS_HOLD:  s_next.hold  = writedata[CW-1:0];
               trig_pkg::OFS_HYST:  s_next.hyst  = writedata[SW-1:0];
               trig_pkg::OFS_CMD: begin
                  if (writedata[trig_pkg::CMD_ARM_BIT]) begin
                     s_next.st = trig_pkg::ST_ARMED;
                     s_next.in_pulse = 1'b0;
                  end
                  if (writedata[trig_pkg::CMD_CLRPK_BIT]) begin
                     s_next.pk_max = '0;
                     s_next.pk_min = '1;
                  end
                  if (writedata[trig_pkg::CMD_FIND_BIT]) begin
                     // Refusal is sticky until next find
                     if (src == trig_pkg::SRC_EXT ||
                         src == trig_pkg::SRC_LINE) begin
                        s_next.refused = 1'b1;
                     end else begin
                        s_next.refused = 1'b0;
                        // Half the peak-to-peak span, not offset by
                        // the minimum
                        s_next.level = SW'((s_reg.pk_max - s_reg.pk_min)
                                           >> 1);
                     end
                  end
               end
               default: ;
            endcase
         end else if (read && !s_reg.ack) begin
            // Reads decode at the stall edge; data then stands until the
            // next read, since writes leave it alone
            case (address)
               trig_pkg::OFS_CTRL:  s_next.rdata = s_reg.ctrl;
               trig_pkg::OFS_LEVEL: s_next.rdata = 32'(s_reg.level);
               trig_pkg::OFS_UPPER: s_next.rdata = 32'(s_reg.upper);
               trig_pkg::OFS_LOWER: s_next.rdata = 32'(s_reg.lower);
               trig_pkg::OFS_WIDTH: s_next.rdata = 32'(s_reg.width);
               trig_pkg::OFS_DELTA: s_next.rdata = 32'(s_reg.delta);
               trig_pkg::OFS_HOLD:  s_next.rdata = 32'(s_reg.hold);
               trig_pkg::OFS_HYST:  s_next.rdata = 32'(s_reg.hyst);
               trig_pkg::OFS_STATUS:
                  s_next.rdata = {27'h0, !type_ok, s_reg.refused,
                                  s_reg.above, s_reg.st};
               trig_pkg::OFS_PEAKS:
                  s_next.rdata = {16'(s_reg.pk_max), 16'(s_reg.pk_min)};
               default: s_next.rdata = 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Synchronous reset; peak minimum starts at full scale so the first
   // sample after reset becomes the new minimum
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_reg        <= '0;
         s_reg.ctrl   <= trig_pkg::CTRL_RESET;
         s_reg.level  <= SW'(trig_pkg::LEVEL_RESET);
         s_reg.hyst   <= SW'(trig_pkg::HYST_RESET);
         s_reg.pk_min <= '1;
         s_reg.st     <= trig_pkg::ST_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   // Waitrequest is combinational so a request stalls in its first cycle
   assign readdata    = s_reg.rdata;
   assign waitrequest = (read || write) && !s_reg.ack;
   assign trig_pulse  = s_reg.trig;
   assign armed       = s_reg.st == trig_pkg::ST_ARMED;
endmodule
`default_nettype wire

// *** design/trig_pkg.sv ***
`default_nettype none
package trig_pkg;
   // ----------------------------------------
   // Register map (word aligned byte offsets)
   // ----------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_LEVEL  = 8'h04;
   localparam logic [7:0] OFS_UPPER  = 8'h08;
   localparam logic [7:0] OFS_LOWER  = 8'h0c;
   localparam logic [7:0] OFS_WIDTH  = 8'h10;
   localparam logic [7:0] OFS_DELTA  = 8'h14;
   localparam logic [7:0] OFS_HOLD   = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1c;
   localparam logic [7:0] OFS_PEAKS  = 8'h20;
   localparam logic [7:0] OFS_CMD    = 8'h24;
   localparam logic [7:0] OFS_HYST   = 8'h28;

   // ----------------------------------------
   // Control field positions
   // ----------------------------------------
   localparam int CTRL_SRC_LSB   = 0;   // 5 bits
   localparam int CTRL_TYPE_LSB  = 8;   // 3 bits
   localparam int CTRL_SLOPE_LSB = 12;  // 2 bits
   localparam int CTRL_RANGE_LSB = 16;  // 2 bits
   localparam int CTRL_NREJ_BIT  = 20;
   localparam int CTRL_SEQ_BIT   = 21;

   localparam int CMD_ARM_BIT    = 0;
   localparam int CMD_FIND_BIT   = 1;
   localparam int CMD_CLRPK_BIT  = 2;

   localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
   localparam logic [15:0] LEVEL_RESET = 16'h0000;
   localparam logic [15:0] HYST_RESET  = 16'h0010;

   // ----------------------------------------
   // Source codes
   // ----------------------------------------
   localparam logic [4:0] SRC_ANALOG = 5'h00;  // 0..3 analog channels
   localparam logic [4:0] SRC_EXT    = 5'h04;
   localparam logic [4:0] SRC_LINE   = 5'h05;
   localparam logic [4:0] SRC_BUS    = 5'h06;
   localparam logic [4:0] SRC_DIG    = 5'h10;  // 0x10..0x1f digital

   typedef enum logic [2:0] {
      TYP_EDGE    = 3'b000,
      TYP_GLITCH  = 3'b001,
      TYP_WIDTH   = 3'b010,
      TYP_RUNT    = 3'b011,
      TYP_WINDOW  = 3'b100,
      TYP_TIMEOUT = 3'b101,
      TYP_INTERV  = 3'b110,
      TYP_SLEW    = 3'b111
   } trig_type_t;

   typedef enum logic [1:0] {
      SLP_POS    = 2'b00,
      SLP_NEG    = 2'b01,
      SLP_EITHER = 2'b10
   } slope_t;

   // Width range: glitch uses only shorter/longer
   typedef enum logic [1:0] {
      RNG_SHORTER = 2'b00,
      RNG_LONGER  = 2'b01,
      RNG_WITHIN  = 2'b10,
      RNG_OUTSIDE = 2'b11
   } range_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ARMED = 2'b01,
      ST_POST  = 2'b10,
      ST_HOLD  = 2'b11
   } acq_state_t;
endpackage
`default_nettype wire

// *** tb/waveform_trigger_detector_props.sv ***
`default_nettype none
module waveform_trigger_detector_props #(
   parameter int NCH = 4,
   parameter int SW  = 16,
   parameter int CW  = 32
) (
   // Clock and reset
   input wire logic              clk,
   input wire logic              reset_n,
   // Sample sources
   input wire logic [NCH*SW-1:0] analog_in,
   input wire logic [SW-1:0]     ext_in,
   input wire logic [SW-1:0]     line_in,
   input wire logic [15:0]       digital_in,
   input wire logic              bus_event,
   // Register bus
   input wire logic [7:0]        address,
   input wire logic              read,
   input wire logic              write,
   input wire logic [31:0]       writedata,
   input wire logic [31:0]       readdata,
   input wire logic              waitrequest,
   // Trigger output
   input wire logic              trig_pulse,
   input wire logic              armed
);
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------
   // Port timing
   // ------------------------------
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // Every access stalls once, then completes
   a_wait_two_cycle: assert property (
      $rose(read || write) |-> waitrequest ##1 !waitrequest)
      else $error("access not answered on its second cycle");
   a_wait_idle: assert property (!(read || write) |-> !waitrequest)
      else $error("stall with no request");
   // Read data only moves after a read is taken
   a_read_hold: assert property (
      !(read && waitrequest) |=> $stable(readdata))
      else $error("read data moved without a read");
   // Trigger is a single pulse out of the armed state
   a_pulse_one: assert property (
      trig_pulse |=> !trig_pulse)
      else $error("trigger pulse longer than one cycle");
   a_pulse_armed: assert property (
      trig_pulse |-> $past(armed))
      else $error("trigger while not armed");
   a_pulse_disarms: assert property (
      trig_pulse |-> !armed)
      else $error("still armed on trigger");
   // Post count and holdoff take at least two cycles
   a_holdoff_gap: assert property (
      trig_pulse |=> !trig_pulse [*3])
      else $error("trigger inside holdoff");
   a_armed_drop: assert property (
      $fell(armed) |-> trig_pulse)
      else $error("armed dropped without trigger");
endmodule

bind waveform_trigger_detector waveform_trigger_detector_props #(
   .NCH(NCH), .SW(SW), .CW(CW)
) props_i (
   .clk(clk), .reset_n(reset_n), .analog_in(analog_in),
   .ext_in(ext_in), .line_in(line_in), .digital_in(digital_in),
   .bus_event(bus_event), .address(address), .read(read),
   .write(write), .writedata(writedata), .readdata(readdata),
   .waitrequest(waitrequest), .trig_pulse(trig_pulse), .armed(armed)
);
`default_nettype wire

// *** tb/waveform_trigger_detector_bench.sv ***
`default_nettype none
module waveform_trigger_detector_bench;
   timeunit 1ns;
   timeprecision 100ps;
   // Driven inputs and watched outputs
   logic        clk         = 1'b0;
   logic        reset_n     = 1'b0;
   logic [63:0] analog_in   = '0;
   logic [15:0] ext_in      = '0;
   logic [15:0] line_in     = '0;
   logic [15:0] digital_in  = '0;
   logic        bus_event   = 1'b0;
   logic [7:0]  address     = '0;
   logic        read        = 1'b0;
   logic        write       = 1'b0;
   logic [31:0] writedata   = '0;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        trig_pulse;
   logic        armed;
   int          err_total   = 0;
   int          tests_run   = 0;

   waveform_trigger_detector uut (
      .clk(clk), .reset_n(reset_n), .analog_in(analog_in),
      .ext_in(ext_in), .line_in(line_in), .digital_in(digital_in),
      .bus_event(bus_event), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .trig_pulse(trig_pulse), .armed(armed)
   );

   // 40 MHz sample clock
   always #12.5 clk = ~clk;

   // ------------------------------
   // Shared helpers
   // ------------------------------
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Request held until waitrequest is low at a rising edge
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      address   <= a;
      writedata <= d;
      write     <= w;
      read      <= ~w;
      do @(negedge clk); while (waitrequest !== 1'b0);
      q = readdata;
      @(posedge clk);
      write <= 1'b0;
      read  <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      acc(1'b1, a, d, q);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
      logic [31:0] q;
      acc(1'b0, a, 32'h0, q);
      chk(nm, e, q);
   endtask
   task automatic put(input logic [15:0] v, input int n);
      analog_in <= {48'h0, v};
      repeat (n) @(posedge clk);
   endtask
   // Window covers post count and holdoff, so pulses are counted
   task automatic watch(input int e);
      int hits;
      hits = 0;
      repeat (24) begin
         @(negedge clk);
         if (trig_pulse === 1'b1) hits++;
      end
      @(posedge clk);
      chk("trigger_count", 32'(e), 32'(hits));
   endtask
   function automatic logic [31:0] cw(logic [4:0] s, logic [2:0] t,
                                      logic [1:0] sl, rg);
      return {14'h0, rg, 2'h0, sl, 1'h0, t, 3'h0, s};
   endfunction
   task automatic p(input logic [2:0] t, input logic [1:0] sl, rg,
                    input logic [31:0] dl, input int n, e);
      logic [15:0] b;
      b = (sl == 2'd1) ? 16'hf000 : 16'h1000;
      wr(trig_pkg::OFS_CTRL, cw(5'h0, t, sl, rg));
      wr(trig_pkg::OFS_DELTA, dl);
      put(b, 2);
      wr(trig_pkg::OFS_CMD, 32'h1);
      put(~b, n);
      put(b, 1);
      watch(e);
   endtask

   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_regs;
      rdc("ctrl", trig_pkg::OFS_CTRL, trig_pkg::CTRL_RESET);
      rdc("level", trig_pkg::OFS_LEVEL, 32'(trig_pkg::LEVEL_RESET));
      rdc("hyst", trig_pkg::OFS_HYST, 32'(trig_pkg::HYST_RESET));
      wr(8'h40, 32'hffff_ffff);
      rdc("unmapped", 8'h40, 32'h0);
      wr(trig_pkg::OFS_LEVEL, 32'h8000);
      rdc("level", trig_pkg::OFS_LEVEL, 32'h8000);
      wr(trig_pkg::OFS_WIDTH, 32'h5);
      wr(trig_pkg::OFS_HOLD, 32'h3);
   endtask
   // Each slope against a rising and a falling crossing
   task automatic t_edge;
      logic [1:0] s;
      for (int i = 0; i < 6; i++) begin
         s = 2'(i / 2);
         wr(trig_pkg::OFS_CTRL, cw(5'h0, 3'h0, s, 2'h0));
         put((i % 2) ? 16'hf000 : 16'h1000, 3);
         wr(trig_pkg::OFS_CMD, 32'h1);
         chk("armed", 32'h1, {31'h0, armed});
         put((i % 2) ? 16'h1000 : 16'hf000, 1);
         watch((i % 2) ? int'(s != 2'd0) : int'(s != 2'd1));
      end
   endtask
   task automatic t_pulse;
      p(3'h1, 2'h0, 2'h0, 32'h0, 3, 1);
      p(3'h1, 2'h0, 2'h0, 32'h0, 5, 0);
      p(3'h1, 2'h0, 2'h1, 32'h0, 8, 1);
      p(3'h1, 2'h1, 2'h0, 32'h0, 3, 1);
      p(3'h2, 2'h0, 2'h2, 32'h0, 5, 1);
      p(3'h2, 2'h0, 2'h2, 32'h0, 6, 0);
      p(3'h2, 2'h0, 2'h3, 32'h0, 6, 1);
      p(3'h2, 2'h0, 2'h2, 32'h2, 7, 1);
      p(3'h2, 2'h0, 2'h2, 32'h2, 8, 0);
      p(3'h2, 2'h0, 2'h0, 32'h0, 4, 1);
      p(3'h2, 2'h0, 2'h1, 32'h0, 4, 0);
   endtask
   // Digital, bus, line and external sources
   task automatic t_src;
      wr(trig_pkg::OFS_CTRL, cw(5'h13, 3'h0, 2'h0, 2'h0));
      wr(trig_pkg::OFS_CMD, 32'h1);
      digital_in <= 16'h0008;
      watch(1);
      wr(trig_pkg::OFS_CTRL, cw(5'h06, 3'h0, 2'h0, 2'h0));
      wr(trig_pkg::OFS_CMD, 32'h1);
      bus_event <= 1'b1;
      @(posedge clk);
      bus_event <= 1'b0;
      watch(1);
      wr(trig_pkg::OFS_CTRL, cw(5'h05, 3'h0, 2'h0, 2'h0));
      wr(trig_pkg::OFS_CMD, 32'h1);
      line_in <= 16'hf000;
      watch(1);
      ext_in <= 16'h7000;
      wr(trig_pkg::OFS_CTRL, cw(5'h04, 3'h0, 2'h0, 2'h0) | 32'h0010_0000);
      wr(trig_pkg::OFS_CMD, 32'h1);
      ext_in <= 16'h8004;
      watch(0);
      ext_in <= 16'h9000;
      watch(1);
   endtask
   // Source and type pairs flagged in status; the last refused one never fires
   task automatic t_legal;
      logic [31:0] q;
      logic [31:0] c [7];
      logic [6:0]  bad;
      c = '{32'h0104, 32'h0004, 32'h0310, 32'h051f, 32'h0205,
            32'h0020_0000, 32'h0020_0004};
      bad = 7'b1110101;
      ext_in <= 16'h1000;
      for (int i = 0; i < 7; i++) begin
         wr(trig_pkg::OFS_CTRL, c[i]);
         acc(1'b0, trig_pkg::OFS_STATUS, 32'h0, q);
         chk("type_bad", 32'(bad[i]), 32'(q[4]));
      end
      wr(trig_pkg::OFS_CMD, 32'h1);
      ext_in <= 16'hf000;
      watch(0);
   endtask
   task automatic t_find;
      logic [31:0] q;
      wr(trig_pkg::OFS_CTRL, 32'h0);
      put(16'h0100, 2);
      wr(trig_pkg::OFS_CMD, 32'h4);
      put(16'h0900, 2);
      wr(trig_pkg::OFS_CMD, 32'h2);
      rdc("level", trig_pkg::OFS_LEVEL, 32'h0400);
      for (int i = 0; i < 2; i++) begin
         wr(trig_pkg::OFS_CTRL, i ? 32'h5 : 32'h4);
         wr(trig_pkg::OFS_CMD, 32'h2);
         acc(1'b0, trig_pkg::OFS_STATUS, 32'h0, q);
         chk("refused", 32'h1, {31'h0, q[3]});
         rdc("level", trig_pkg::OFS_LEVEL, 32'h0400);
      end
   endtask

   // Two thresholds for runt, then timeout on the single level
   task automatic t_thr;
      logic [31:0] q;
      wr(trig_pkg::OFS_UPPER, 32'h9000);
      wr(trig_pkg::OFS_LOWER, 32'h7000);
      wr(trig_pkg::OFS_CTRL, cw(5'h0, 3'h3, 2'h0, 2'h0));
      for (int i = 0; i < 3; i++) begin
         put((i == 1) ? 16'ha000 : 16'h8800, 2);
         acc(1'b0, trig_pkg::OFS_STATUS, 32'h0, q);
         chk("above", 32'(i != 0), 32'(q[2]));
      end
      wr(trig_pkg::OFS_CTRL, cw(5'h0, 3'h5, 2'h0, 2'h0));
      wr(trig_pkg::OFS_CMD, 32'h1);
      put(16'h0100, 1);
      watch(1);
   endtask

   // Main sequence after a 16-cycle reset
   initial begin
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_regs;
      t_edge;
      t_pulse;
      t_src;
      t_legal;
      t_find;
      t_thr;
      tally_and_finish;
   end
   // Watchdog, well beyond the thousand or so cycles needed
   initial begin
      repeat (40000) @(posedge clk);
      err_total++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
